/* include/rrl_pkg.sv */
// Package for the repeater reset and link-control register bank.
// Assumes one 125 MHz device clock and a byte-wide register map.
package rrl_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] OFS_RESERVED = 8'h00;
   localparam logic [7:0] OFS_SOFT_RESET = 8'h01;
   localparam logic [7:0] OFS_LINK_CTRL = 8'h02;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int SOFT_RESET_BIT = 0;
   localparam int SPEED_MSB = 7;
   localparam int SPEED_LSB = 6;
   localparam int ROLE_MSB = 5;
   localparam int ROLE_LSB = 4;
   localparam int UNUSED_LINK_BIT = 3;
   localparam int MODE_MSB = 2;
   localparam int MODE_LSB = 0;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [1:0] SPEED_RESET = 2'h0;
   localparam logic [1:0] ROLE_RESET = 2'h0;
   localparam logic [2:0] MODE_RESET = 3'h0;

   ////////////////////////////////////////////////////////////////////////
   // Encodings
   localparam logic [1:0] SPEED_AUTO = 2'h0;
   localparam logic [1:0] SPEED_LS_FS = 2'h1;
   localparam logic [1:0] ROLE_DUAL = 2'h0;
   localparam logic [1:0] ROLE_HOST = 2'h1;
   localparam logic [1:0] ROLE_DEVICE = 2'h2;
   localparam logic [2:0] MODE_AUTO = 3'h0;
   localparam logic [2:0] MODE_STANDBY = 3'h1;
   localparam logic [2:0] MODE_CONNECT = 3'h2;
   localparam logic [2:0] MODE_COMPLIANCE = 3'h3;

   ////////////////////////////////////////////////////////////////////////
   // Serial target timing
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   typedef enum logic [5:0] {
      RRL_IDLE = 6'b000001,
      RRL_ADDR = 6'b000010,
      RRL_ACK = 6'b000100,
      RRL_WR = 6'b001000,
      RRL_RD = 6'b010000,
      RRL_RACK = 6'b100000
   } rrl_state_e;

endpackage : rrl_pkg

/* core/rrl_ctrl_regs.sv */
// Reset and link-control register bank behind a two-wire serial target.
// Assumes scl/sda come from pins; the eUSB2 message logic shares clock.
module rrl_ctrl_regs #(
   parameter logic [6:0] TARGET_ADDR = 7'h2A  // Arbitrary value
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic cfg_msg_valid,
   input wire logic cfg_msg_host,
   output logic cfg_msg_ack,
   output logic usb_host_role,
   output logic force_host,
   output logic force_device,
   output logic speed_ls_fs_only,
   output logic [2:0] op_mode,
   output logic connect_detect_pulse,
   output logic compliance_pulse,
   output logic soft_reset_pulse
);

   // Refused at elaboration; these addresses are kept for bus use
   if (TARGET_ADDR[6:3] == 4'h0) begin : g_bad_addr
      $error("Target address in reserved range");
   end

   function automatic logic one_role_bit(input logic [1:0] role);
      return role == rrl_pkg::ROLE_HOST || role == rrl_pkg::ROLE_DEVICE;
   endfunction : one_role_bit

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; level changes once stages two and three agree
   logic [2:0] scl_sync_reg;
   logic [2:0] sda_sync_reg;
   logic scl_reg;
   logic sda_reg;
   logic scl_prev_reg;
   logic sda_prev_reg;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
         sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
         if (scl_sync_reg[1] == scl_sync_reg[2]) begin
            scl_reg <= scl_sync_reg[2];
         end
         if (sda_sync_reg[1] == sda_sync_reg[2]) begin
            sda_reg <= sda_sync_reg[2];
         end
         scl_prev_reg <= scl_reg;
         sda_prev_reg <= sda_reg;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   assign scl_rise = scl_reg && !scl_prev_reg;
   assign scl_fall = !scl_reg && scl_prev_reg;
   assign start_seen = scl_reg && scl_prev_reg && sda_prev_reg && !sda_reg;
   assign stop_seen = scl_reg && scl_prev_reg && !sda_prev_reg && sda_reg;

   ////////////////////////////////////////////////////////////////////////
   // Serial target protocol
   rrl_pkg::rrl_state_e state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [7:0] ptr_reg;
   logic read_reg;
   logic ptr_phase_reg;
   logic sda_oe_reg;
   logic wr_stb;
   logic [7:0] rd_data;

   // Always open, no enable step before access
   assign wr_stb = scl_fall && state_reg == rrl_pkg::RRL_WR &&
                   bit_cnt_reg == rrl_pkg::BITS_PER_BYTE && !ptr_phase_reg;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= rrl_pkg::RRL_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         ptr_reg <= 8'h00;
         read_reg <= 1'b0;
         ptr_phase_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else if (start_seen) begin
         state_reg <= rrl_pkg::RRL_ADDR;
         bit_cnt_reg <= 4'h0;
         sda_oe_reg <= 1'b0;
      end else if (stop_seen) begin
         state_reg <= rrl_pkg::RRL_IDLE;
         sda_oe_reg <= 1'b0;
      end else if (scl_rise) begin
         if (state_reg == rrl_pkg::RRL_ADDR || state_reg == rrl_pkg::RRL_WR ||
             state_reg == rrl_pkg::RRL_RD) begin
            shift_reg <= {shift_reg[6:0], sda_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end else if (state_reg == rrl_pkg::RRL_RACK) begin
            read_reg <= !sda_reg;  // Low means controller wants more
         end
      end else if (scl_fall) begin
         unique case (state_reg)
            rrl_pkg::RRL_IDLE: begin
               sda_oe_reg <= 1'b0;
            end
            rrl_pkg::RRL_ADDR: begin
               if (bit_cnt_reg == rrl_pkg::BITS_PER_BYTE) begin
                  if (shift_reg[7:1] == TARGET_ADDR) begin
                     read_reg <= shift_reg[0];
                     ptr_phase_reg <= !shift_reg[0];
                     sda_oe_reg <= 1'b1;
                     state_reg <= rrl_pkg::RRL_ACK;
                  end else begin
                     state_reg <= rrl_pkg::RRL_IDLE;
                  end
               end
            end
            rrl_pkg::RRL_ACK: begin
               bit_cnt_reg <= 4'h0;
               if (read_reg) begin
                  tx_reg <= {rd_data[6:0], 1'b0};
                  sda_oe_reg <= !rd_data[7];
                  ptr_reg <= ptr_reg + 8'h01;
                  state_reg <= rrl_pkg::RRL_RD;
               end else begin
                  sda_oe_reg <= 1'b0;
                  state_reg <= rrl_pkg::RRL_WR;
               end
            end
            rrl_pkg::RRL_WR: begin
               if (bit_cnt_reg == rrl_pkg::BITS_PER_BYTE) begin
                  if (ptr_phase_reg) begin
                     ptr_reg <= shift_reg;
                     ptr_phase_reg <= 1'b0;
                  end else begin
                     ptr_reg <= ptr_reg + 8'h01;
                  end
                  sda_oe_reg <= 1'b1;
                  state_reg <= rrl_pkg::RRL_ACK;
               end
            end
            rrl_pkg::RRL_RD: begin
               if (bit_cnt_reg == rrl_pkg::BITS_PER_BYTE) begin
                  sda_oe_reg <= 1'b0;
                  state_reg <= rrl_pkg::RRL_RACK;
               end else begin
                  sda_oe_reg <= !tx_reg[7];
                  tx_reg <= {tx_reg[6:0], 1'b0};
               end
            end
            rrl_pkg::RRL_RACK: begin
               // On a controller ack, loads the next byte here as the ACK state does, then goes straight to RRL_RD; on a nack goes to RRL_IDLE
               state_reg <= read_reg ? rrl_pkg::RRL_ACK : rrl_pkg::RRL_IDLE;
               read_reg <= 1'b1;
               if (read_reg) begin
                  bit_cnt_reg <= 4'h0;
                  tx_reg <= {rd_data[6:0], 1'b0};
                  sda_oe_reg <= !rd_data[7];
                  ptr_reg <= ptr_reg + 8'h01;
                  state_reg <= rrl_pkg::RRL_RD;
               end
            end
         endcase
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = sda_oe_reg;

   ////////////////////////////////////////////////////////////////////////
   // Register file
   logic [1:0] speed_reg;
   logic [1:0] role_reg;
   logic [2:0] mode_reg;
   logic soft_reset_reg;
   logic soft_reset_next;

   // Only a one starts the reset; the bit itself is never stored
   assign soft_reset_next = wr_stb && ptr_reg == rrl_pkg::OFS_SOFT_RESET &&
                            shift_reg[rrl_pkg::SOFT_RESET_BIT];

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         soft_reset_reg <= 1'b0;
      end else begin
         soft_reset_reg <= soft_reset_next;
      end
   end

   // Reserved encodings are stored as written; behaviour not guaranteed
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         speed_reg <= rrl_pkg::SPEED_RESET;
         role_reg <= rrl_pkg::ROLE_RESET;
         mode_reg <= rrl_pkg::MODE_RESET;
      end else if (soft_reset_reg) begin
         speed_reg <= rrl_pkg::SPEED_RESET;
         role_reg <= rrl_pkg::ROLE_RESET;
         mode_reg <= rrl_pkg::MODE_RESET;
      end else if (wr_stb && ptr_reg == rrl_pkg::OFS_LINK_CTRL) begin
         speed_reg <= shift_reg[rrl_pkg::SPEED_MSB:rrl_pkg::SPEED_LSB];
         role_reg <= shift_reg[rrl_pkg::ROLE_MSB:rrl_pkg::ROLE_LSB];
         mode_reg <= shift_reg[rrl_pkg::MODE_MSB:rrl_pkg::MODE_LSB];
      end
   end

   always_comb begin
      rd_data = 8'h00;
      if (ptr_reg == rrl_pkg::OFS_LINK_CTRL) begin
         rd_data[rrl_pkg::SPEED_MSB:rrl_pkg::SPEED_LSB] = speed_reg;
         rd_data[rrl_pkg::ROLE_MSB:rrl_pkg::ROLE_LSB] = role_reg;
         rd_data[rrl_pkg::MODE_MSB:rrl_pkg::MODE_LSB] = mode_reg;
         rd_data[rrl_pkg::UNUSED_LINK_BIT] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode commands act only at the write itself
   logic [7:0] wr_byte;
   logic link_wr;
   assign wr_byte = shift_reg;
   assign link_wr = wr_stb && ptr_reg == rrl_pkg::OFS_LINK_CTRL;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         connect_detect_pulse <= 1'b0;
         compliance_pulse <= 1'b0;
      end else begin
         connect_detect_pulse <= link_wr &&
            wr_byte[rrl_pkg::MODE_MSB:rrl_pkg::MODE_LSB] ==
               rrl_pkg::MODE_CONNECT &&
            one_role_bit(wr_byte[rrl_pkg::ROLE_MSB:rrl_pkg::ROLE_LSB]);
         compliance_pulse <= link_wr &&
            wr_byte[rrl_pkg::MODE_MSB:rrl_pkg::MODE_LSB] ==
               rrl_pkg::MODE_COMPLIANCE &&
            one_role_bit(wr_byte[rrl_pkg::ROLE_MSB:rrl_pkg::ROLE_LSB]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Role resolution and configuration message handling
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         usb_host_role <= 1'b0;
         cfg_msg_ack <= 1'b0;
      end else begin
         cfg_msg_ack <= cfg_msg_valid;
         if (role_reg == rrl_pkg::ROLE_HOST) begin
            usb_host_role <= 1'b1;
         end else if (role_reg == rrl_pkg::ROLE_DEVICE) begin
            usb_host_role <= 1'b0;
         end else if (cfg_msg_valid) begin
            usb_host_role <= cfg_msg_host;
         end
      end
   end

   assign force_host = role_reg == rrl_pkg::ROLE_HOST;
   assign force_device = role_reg == rrl_pkg::ROLE_DEVICE;
   assign speed_ls_fs_only = speed_reg == rrl_pkg::SPEED_LS_FS;
   assign op_mode = mode_reg;
   assign soft_reset_pulse = soft_reset_reg;

endmodule : rrl_ctrl_regs

/* dv/rrl_ctrl_regs_asserts.sv */
// Port checker for the reset and link-control register bank.
// Assumes one clock domain; bound to every rrl_ctrl_regs instance.
module rrl_ctrl_regs_asserts (
   input wire logic clock,
   input wire logic nrst,
   input wire logic cfg_msg_valid,
   input wire logic cfg_msg_host,
   input wire logic cfg_msg_ack,
   input wire logic usb_host_role,
   input wire logic force_host,
   input wire logic force_device,
   input wire logic speed_ls_fs_only,
   input wire logic [2:0] op_mode,
   input wire logic connect_detect_pulse,
   input wire logic compliance_pulse,
   input wire logic soft_reset_pulse
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   //////////////////////////////////////////////////
   property p_ack; cfg_msg_valid |=> cfg_msg_ack; endproperty
   a_ack: assert property (p_ack)
      else $error("config message not acknowledged");
   property p_host; force_host && $past(force_host) |-> usb_host_role;
   endproperty
   a_host: assert property (p_host)
      else $error("forced host role lost");
   property p_dev; force_device && $past(force_device) |-> !usb_host_role;
   endproperty
   a_dev: assert property (p_dev)
      else $error("forced device role lost");
   property p_dual; cfg_msg_valid && !force_host && !force_device
      |=> usb_host_role == $past(cfg_msg_host); endproperty
   a_dual: assert property (p_dual)
      else $error("dual role did not follow message");
   property p_conn; connect_detect_pulse |-> op_mode ==
      rrl_pkg::MODE_CONNECT && force_host != force_device; endproperty
   a_conn: assert property (p_conn)
      else $error("connect pulse without mode 2 and one role");
   property p_comp; compliance_pulse |-> op_mode ==
      rrl_pkg::MODE_COMPLIANCE && force_host != force_device; endproperty
   a_comp: assert property (p_comp)
      else $error("compliance pulse without one role bit");
   property p_conn_one; connect_detect_pulse |=> !connect_detect_pulse;
   endproperty
   a_conn_one: assert property (p_conn_one)
      else $error("connect pulse longer than one cycle");
   property p_srst; soft_reset_pulse |-> ##[0:1] (op_mode ==
      rrl_pkg::MODE_RESET &&
      !force_host && !force_device && !speed_ls_fs_only); endproperty
   a_srst: assert property (p_srst)
      else $error("software reset left fields set");
   property p_srst_one; soft_reset_pulse |=> !soft_reset_pulse; endproperty
   a_srst_one: assert property (p_srst_one)
      else $error("software reset did not clear itself");
endmodule : rrl_ctrl_regs_asserts
bind rrl_ctrl_regs rrl_ctrl_regs_asserts rrl_ctrl_regs_asserts_i (.clock,
   .nrst, .cfg_msg_valid, .cfg_msg_host, .cfg_msg_ack, .usb_host_role,
   .force_host, .force_device, .speed_ls_fs_only, .op_mode,
   .connect_detect_pulse, .compliance_pulse, .soft_reset_pulse);

/* dv/rrl_i2c_ctrl.sv */
// Two-wire bus controller model driving the register bank's pins.
// Assumes a pull-up on sda; scl stands high outside transfers.
module rrl_i2c_ctrl (
   input wire logic clock,
   input wire logic sda_line,
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   int half = 8;
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   //////////////////////////////////////////////////
   task automatic hp();
      repeat (half) @(negedge clock);
   endtask : hp
   // Data moves two cycles after scl falls, never with the edge
   task automatic bt(input logic b, output logic r);
      repeat (2) @(negedge clock);
      sda = b;
      hp();
      scl = 1'b1;
      hp();
      r = sda_line;
      scl = 1'b0;
   endtask : bt
   task automatic start();
      repeat (2) @(negedge clock);
      sda = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      sda = 1'b0;
      hp();
      scl = 1'b0;
   endtask : start
   task automatic stop();
      repeat (2) @(negedge clock);
      sda = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      sda = 1'b1;
      hp();
   endtask : stop
   // Ninth bit released: target ack on writes, our nack on reads
   task automatic xfer(input logic [7:0] d, output logic [7:0] q,
      output logic a);
      logic r;
      for (int i = 0; i < 8; i++) begin
         bt(d[7 - i], r);
         q = {q[6:0], r};
      end
      bt(1'b1, a);
   endtask : xfer
   task automatic wr(input logic [6:0] adr, input logic [7:0] ofs,
      input logic [7:0] d, output logic nak);
      logic [7:0] q;
      logic a0, a1, a2;
      start();
      xfer({adr, 1'b0}, q, a0);
      xfer(ofs, q, a1);
      xfer(d, q, a2);
      stop();
      nak = a0 | a1 | a2;
   endtask : wr
   task automatic rd(input logic [6:0] adr, input logic [7:0] ofs,
      output logic [7:0] q);
      logic a;
      start();
      xfer({adr, 1'b0}, q, a);
      xfer(ofs, q, a);
      start();
      xfer({adr, 1'b1}, q, a);
      xfer(8'hFF, q, a);
      stop();
   endtask : rd
endmodule : rrl_i2c_ctrl

/* dv/tb_top.sv */
// Testbench for the reset and link-control register bank.
// Assumes the controller model owns scl/sda; sda is wired-and.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] ADDR = 7'h2A;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic cfg_msg_valid = 1'b0;
   logic cfg_msg_host = 1'b0;
   logic scl, m_sda, sda_out, sda_oe, sda_line, cfg_msg_ack, nak;
   logic usb_host_role, force_host, force_device, speed_ls_fs_only;
   logic connect_detect_pulse, compliance_pulse, soft_reset_pulse;
   logic [2:0] op_mode;
   logic [7:0] q;
   int n_fail = 0, samples_checked = 0, cyc = 0;
   int n_conn = 0, n_comp = 0, n_srst = 0;
   assign sda_line = m_sda & ~(sda_oe & ~sda_out);
   initial forever #4 clock = ~clock;
   rrl_ctrl_regs #(.TARGET_ADDR(ADDR)) rrl_ctrl_regs_i (.clock, .nrst,
      .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe, .cfg_msg_valid,
      .cfg_msg_host, .cfg_msg_ack, .usb_host_role, .force_host,
      .force_device, .speed_ls_fs_only, .op_mode, .connect_detect_pulse,
      .compliance_pulse, .soft_reset_pulse);
   rrl_i2c_ctrl rrl_i2c_ctrl_i (.clock, .sda_line, .scl, .sda(m_sda));
   //////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
      rrl_i2c_ctrl_i.wr(ADDR, ofs, d, nak);
      chk({7'h00, nak}, 8'h00);
   endtask : wr
   task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
      rrl_i2c_ctrl_i.rd(ADDR, ofs, q);
      chk(q, exp);
   endtask : rd
   task automatic msg(input logic h, input logic role);
      cfg_msg_valid = 1'b1;
      cfg_msg_host = h;
      @(negedge clock);
      cfg_msg_valid = 1'b0;
      chk({7'h00, cfg_msg_ack}, 8'h01);
      @(negedge clock);
      chk({7'h00, usb_host_role}, {7'h00, role});
   endtask : msg
   // Pulses counted on every rising clock edge so none slips between checks
   always @(posedge clock) begin
      cyc++;
      if (connect_detect_pulse === 1'b1) n_conn++;
      if (compliance_pulse === 1'b1) n_comp++;
      if (soft_reset_pulse === 1'b1) n_srst++;
      if (cyc == 60000) begin
         n_fail++;
         end_sim();
      end
   end
   initial begin
      repeat (16) @(negedge clock);
      nrst = 1'b1;
      repeat (8) @(negedge clock);
      rd(8'h00, 8'h00);
      rd(8'h01, 8'h00);
      rd(8'h02, 8'h00);
      wr(8'h00, 8'hFF);
      rd(8'h00, 8'h00);
      wr(8'h02, 8'h12);
      chk({5'h00, op_mode}, 8'h02);
      chk({6'h00, force_host, force_device}, 8'h02);
      chk(n_conn[7:0], 8'h01);
      msg(1'b0, 1'b1);
      wr(8'h02, 8'h22);
      msg(1'b1, 1'b0);
      wr(8'h02, 8'h02);
      wr(8'h02, 8'h03);
      chk({n_conn[3:0], n_comp[3:0]}, 8'h20);
      msg(1'b1, 1'b1);
      msg(1'b0, 1'b0);
      // Slow bus cycles for the compliance command
      rrl_i2c_ctrl_i.half = 20;
      wr(8'h02, 8'h13);
      rrl_i2c_ctrl_i.half = 8;
      chk(n_comp[7:0], 8'h01);
      wr(8'h02, 8'h4A);
      rd(8'h02, 8'h42);
      chk({7'h00, speed_ls_fs_only}, 8'h01);
      wr(8'h01, 8'h00);
      rd(8'h02, 8'h42);
      wr(8'h01, 8'h01);
      chk(n_srst[7:0], 8'h01);
      rd(8'h02, 8'h00);
      rd(8'h01, 8'h00);
      rrl_i2c_ctrl_i.wr(7'h2B, 8'h02, 8'h12, nak);
      chk({7'h00, nak}, 8'h01);
      rd(8'h02, 8'h00);
      end_sim();
   end
endmodule : tb_top
